/* File: lnb_ch2_consts.svh */
// constants for the channel-2 supply control register interface
// Operation
// - tone off, int mod: oscillator gated by pin
// - tone off, ext mod: pin passed through
// - tone on, int mod: oscillator gated by bit
// - threshold bit or transmit pin selects the transmit level
// - range and pair pick the current limit
// - set bit turns dynamic limiting off
// - set bit makes range pin ignored
// - enable low shuts boost and linear off
// - pin ignored: top and bottom bits pick voltage
// - pin low: bottom bit picks 13V or 14V
// - pin high: top bit picks 18V or 19V
// - read address starts msb-first byte output
// - master ack continues, nack ends read
// - read bytes carry diagnostic flags per channel
// - power-good low: bus ignored, registers zero
// - two straps form low address bits
// - read-only fields ignore writes, return status
`ifndef LNB_CH2_CONSTS_SVH
`define LNB_CH2_CONSTS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ          40000000
`define TONE_HZ         22000
`define TONE_HALF_CYC   (`CLK_HZ / (2 * `TONE_HZ))

// ----------------------------------------------------------------
// bus address and register selects
// ----------------------------------------------------------------
`define ADDR_BASE       5'h02
`define SEL_TONE        3'h5
`define SEL_CMD         3'h6
`define SEL_CTRL        3'h7
`define BYTE_BITS       4'h8
`define RD_LAST         2'h3

// ----------------------------------------------------------------
// field positions inside a written byte
// ----------------------------------------------------------------
`define TONE_ENT_BIT    4
`define TONE_MSEL_BIT   3
`define TONE_TTH_BIT    2
`define CMD_DCL_BIT     4
`define CMD_VSPEN_BIT   3
`define CMD_RANGE_BIT   2
`define CMD_HIGH_BIT    1
`define CMD_LOW_BIT     0
`define CTRL_EN_BIT     4
`define CTRL_VTOP_BIT   1
`define CTRL_VBOT_BIT   0

`endif

/* File: lnb_ch2_pkg.sv */
// types for the channel-2 supply control register interface
package lnb_ch2_pkg;

  // bus engine states
  typedef enum logic [2:0] {
    LK_IDLE      = 3'b000,
    LK_ADDR      = 3'b001,
    LK_ADDR_ACK  = 3'b010,
    LK_WRITE     = 3'b011,
    LK_WRITE_ACK = 3'b100,
    LK_READ      = 3'b101,
    LK_READ_ACK  = 3'b110
  } link_state_e;

  // output voltage choice
  typedef enum logic [1:0] {
    VOUT_13V = 2'b00,
    VOUT_14V = 2'b01,
    VOUT_18V = 2'b10,
    VOUT_19V = 2'b11
  } vout_sel_e;

  // current limit choice
  typedef enum logic [2:0] {
    ILIM_275 = 3'b000,
    ILIM_350 = 3'b001,
    ILIM_515 = 3'b010,
    ILIM_635 = 3'b011,
    ILIM_800 = 3'b100
  } ilim_sel_e;

  // writable configuration of channel 2
  typedef struct packed {
    logic ent;    // tone_enable_ch2
    logic msel;   // modulation_select_ch2
    logic tth;    // tone_threshold_ch2
    logic dcl;    // dyn_limit_off_ch2
    logic vspen;  // volt_pin_disable_ch2
    logic rng;    // current_limit_range
    logic hi;     // current_limit_high
    logic lo;     // current_limit_low
    logic en;     // output_enable_ch2
    logic vtop;   // top_voltage_sel_ch2
    logic vbot;   // bottom_voltage_sel_ch2
  } cfg_s;

  // link-clock domain state
  typedef struct packed {
    logic        rst_s1;
    logic        rst_s2;
    logic        pg_s1;
    logic        pg_s2;
    logic        scl_s1;
    logic        scl_s2;
    logic        scl_d;
    logic        sda_s1;
    logic        sda_s2;
    logic        sda_d;
    logic [1:0]  strap_s1;
    logic [1:0]  strap_s2;
    logic [6:0]  diag_s1;
    logic [6:0]  diag_s2;
    link_state_e state;
    logic [3:0]  cnt;
    logic [7:0]  shift;
    logic [1:0]  rd_ptr;
    logic        rw;
    logic        mack;
    cfg_s        cfg;
    logic        wr_tgl;
    logic        sda_oe;
    logic        sda_o;
  } link_s;

  // system clock domain state
  typedef struct packed {
    logic        pg_s1;
    logic        pg_s2;
    logic        tgl_s1;
    logic        tgl_s2;
    logic        tgl_d;
    logic        ext_s1;
    logic        ext_s2;
    logic        hr_s1;
    logic        hr_s2;
    logic        tx_s1;
    logic        tx_s2;
    cfg_s        cfg;
    logic [9:0]  osc_cnt;
    logic        osc;
    logic        tone_out;
    logic        thr_tx;
    ilim_sel_e   ilim;
    logic        dyn_en;
    logic        boost_en;
    logic        ldo_en;
    vout_sel_e   vout;
  } sys_s;

endpackage

/* File: lnb_ch2_i2c_control_regs.sv */
// channel-2 supply control: bus slave, register bank and output decode
`include "lnb_ch2_consts.svh"

module lnb_ch2_i2c_control_regs
  import lnb_ch2_pkg::*;
(
  // system clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // link clock for the bus sampler
  input  wire logic        link_clk,
  // supply lockout power-good, high when supply is fine
  input  wire logic        power_good,
  // two-wire bus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // address straps
  input  wire logic        address_strap_0,
  input  wire logic        address_strap_1,
  // channel-2 control pins
  input  wire logic        ext_mod_in_ch2,
  input  wire logic        high_range_pin_ch2,
  input  wire logic        tone_tx_pin_ch2,
  // diagnostic inputs from the analog side
  input  wire logic        over_temp_flag,
  input  wire logic        current_fault_ch1,
  input  wire logic        voltage_fault_ch1,
  input  wire logic        tone_present_ch1,
  input  wire logic        current_fault_ch2,
  input  wire logic        voltage_fault_ch2,
  input  wire logic        tone_present_ch2,
  // channel-2 power stage controls
  output logic             tone_out_ch2,
  output logic             tone_thresh_tx_ch2,
  output logic [2:0]       ilim_sel_ch2,
  output logic             dyn_limit_en_ch2,
  output logic             boost_en_ch2,
  output logic             ldo_en_ch2,
  output logic [1:0]       vout_sel_ch2
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  link_s lk_reg;   // link domain
  link_s lk_next;
  sys_s  sy_reg;   // system domain
  sys_s  sy_next;

  // read byte for a given pointer, status bits ignore writes
  function automatic logic [7:0] rd_byte(input logic [1:0] ptr,
                                         input cfg_s c,
                                         input logic [6:0] d);
    logic [7:0] b;
    b = 8'h00;
    unique case (ptr)
      2'h0: b = {`SEL_TONE, c.ent, c.msel, c.tth, d[0], d[6]};
      2'h1: b = {`SEL_CMD, c.dcl, c.vspen, c.rng, c.hi, c.lo};
      2'h2: b = {`SEL_CTRL, c.en, d[2], d[1], c.vtop, c.vbot};
      2'h3: b = {d, 1'b0};
    endcase
    return b;
  endfunction

  // ----------------------------------------------------------------
  // link domain: bus sampler and register bank
  // ----------------------------------------------------------------
  // bus pins are oversampled; scl edges are found after two flops
  always_comb
  begin
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;
    logic [7:0] nb;
    rise  = lk_reg.scl_s2 & ~lk_reg.scl_d;
    fall  = lk_reg.scl_d & ~lk_reg.scl_s2;
    start = lk_reg.scl_s2 & lk_reg.scl_d & lk_reg.sda_d & ~lk_reg.sda_s2;
    stop  = lk_reg.scl_s2 & lk_reg.scl_d & ~lk_reg.sda_d & lk_reg.sda_s2;
    nb    = rd_byte(lk_reg.rd_ptr, lk_reg.cfg, lk_reg.diag_s2);
    lk_next = lk_reg;
    if (start)
    begin
      // a start always restarts framing, read pointer back to first byte
      lk_next.state  = LK_ADDR;
      lk_next.cnt    = 4'h0;
      lk_next.sda_oe = 1'b0;
      lk_next.rd_ptr = 2'h0;
    end
    else if (stop)
    begin
      lk_next.state  = LK_IDLE;
      lk_next.sda_oe = 1'b0;
    end
    else
    begin
      unique case (lk_reg.state)
        LK_IDLE:
        begin
          lk_next.sda_oe = 1'b0;
        end
        LK_ADDR, LK_WRITE:
        begin
          if (rise && lk_reg.cnt != `BYTE_BITS)
          begin
            // shift in on scl high
            lk_next.shift = {lk_reg.shift[6:0], lk_reg.sda_s2};
            lk_next.cnt   = lk_reg.cnt + 4'h1;
          end
          else if (fall && lk_reg.cnt == `BYTE_BITS)
          begin
            lk_next.cnt = 4'h0;
            if (lk_reg.state == LK_ADDR)
            begin
              if (lk_reg.shift[7:1] == {`ADDR_BASE, lk_reg.strap_s2})
              begin
                lk_next.sda_oe = 1'b1;
                lk_next.rw     = lk_reg.shift[0];
                lk_next.state  = LK_ADDR_ACK;
              end
              else
              begin
                // other address: stay released until next start
                lk_next.state  = LK_IDLE;
              end
            end
            else
            begin
              // upper bits pick the register, low five are data
              unique case (lk_reg.shift[7:5])
                `SEL_TONE:
                begin
                  lk_next.cfg.ent  = lk_reg.shift[`TONE_ENT_BIT];
                  lk_next.cfg.msel = lk_reg.shift[`TONE_MSEL_BIT];
                  lk_next.cfg.tth  = lk_reg.shift[`TONE_TTH_BIT];
                end
                `SEL_CMD:
                begin
                  lk_next.cfg.dcl   = lk_reg.shift[`CMD_DCL_BIT];
                  lk_next.cfg.vspen = lk_reg.shift[`CMD_VSPEN_BIT];
                  lk_next.cfg.rng   = lk_reg.shift[`CMD_RANGE_BIT];
                  lk_next.cfg.hi    = lk_reg.shift[`CMD_HIGH_BIT];
                  lk_next.cfg.lo    = lk_reg.shift[`CMD_LOW_BIT];
                end
                `SEL_CTRL:
                begin
                  lk_next.cfg.en   = lk_reg.shift[`CTRL_EN_BIT];
                  lk_next.cfg.vtop = lk_reg.shift[`CTRL_VTOP_BIT];
                  lk_next.cfg.vbot = lk_reg.shift[`CTRL_VBOT_BIT];
                end
                default:
                begin
                  // channel-1 and status selects live elsewhere
                  lk_next.cfg = lk_reg.cfg;
                end
              endcase
              lk_next.wr_tgl = ~lk_reg.wr_tgl;
              lk_next.sda_oe = 1'b1;
              lk_next.state  = LK_WRITE_ACK;
            end
          end
        end
        LK_ADDR_ACK:
        begin
          if (fall)
          begin
            if (lk_reg.rw)
            begin
              // first read bit goes out right after the ack clock
              lk_next.shift  = nb;
              lk_next.rd_ptr = lk_reg.rd_ptr + 2'h1;
              lk_next.sda_oe = ~nb[7];
              lk_next.state  = LK_READ;
            end
            else
            begin
              lk_next.sda_oe = 1'b0;
              lk_next.state  = LK_WRITE;
            end
          end
        end
        LK_WRITE_ACK:
        begin
          if (fall)
          begin
            lk_next.sda_oe = 1'b0;
            lk_next.state  = LK_WRITE;
          end
        end
        LK_READ:
        begin
          if (rise)
          begin
            lk_next.cnt = lk_reg.cnt + 4'h1;
          end
          else if (fall)
          begin
            if (lk_reg.cnt == `BYTE_BITS)
            begin
              // release for the master's ninth-clock answer
              lk_next.sda_oe = 1'b0;
              lk_next.cnt    = 4'h0;
              lk_next.state  = LK_READ_ACK;
            end
            else
            begin
              lk_next.shift  = {lk_reg.shift[6:0], 1'b0};
              lk_next.sda_oe = ~lk_reg.shift[6];
            end
          end
        end
        LK_READ_ACK:
        begin
          if (rise)
          begin
            lk_next.mack = ~lk_reg.sda_s2;
          end
          else if (fall)
          begin
            if (lk_reg.mack)
            begin
              lk_next.shift  = nb;
              lk_next.rd_ptr = lk_reg.rd_ptr + 2'h1;
              lk_next.sda_oe = ~nb[7];
              lk_next.state  = LK_READ;
            end
            else
            begin
              lk_next.state  = LK_IDLE;
            end
          end
        end
        default:
        begin
          // illegal code, fall back to idle released
          lk_next.state  = LK_IDLE;
          lk_next.sda_oe = 1'b0;
        end
      endcase
    end
    // lockout: bus ignored and registers cleared, enable comes up low
    if (lk_reg.rst_s2 || !lk_reg.pg_s2)
    begin
      lk_next = '0;
    end
    // synchronisers run through reset so the reset itself can end
    lk_next.rst_s1   = rst;
    lk_next.rst_s2   = lk_reg.rst_s1;
    lk_next.pg_s1    = power_good;
    lk_next.pg_s2    = lk_reg.pg_s1;
    lk_next.scl_s1   = scl_in;
    lk_next.scl_s2   = lk_reg.scl_s1;
    lk_next.scl_d    = lk_reg.scl_s2;
    lk_next.sda_s1   = sda_in;
    lk_next.sda_s2   = lk_reg.sda_s1;
    lk_next.sda_d    = lk_reg.sda_s2;
    lk_next.strap_s1 = {address_strap_1, address_strap_0};
    lk_next.strap_s2 = lk_reg.strap_s1;
    lk_next.diag_s1  = {over_temp_flag, current_fault_ch1, voltage_fault_ch1,
                        tone_present_ch1, current_fault_ch2, voltage_fault_ch2,
                        tone_present_ch2};
    lk_next.diag_s2  = lk_reg.diag_s1;
    lk_next.sda_o    = 1'b0;
  end

  // link domain register
  always_ff @(posedge link_clk)
  begin
    lk_reg <= lk_next;
  end

  // ----------------------------------------------------------------
  // system domain: config copy, tone and power stage decode
  // ----------------------------------------------------------------
  // config crosses by toggle; the bank is stable for a whole byte time
  always_comb
  begin
    logic tgl_edge;
    tgl_edge = sy_reg.tgl_s2 ^ sy_reg.tgl_d;
    sy_next  = sy_reg;
    sy_next.tgl_d = sy_reg.tgl_s2;
    if (!sy_reg.pg_s2)
    begin
      sy_next.cfg = '0;
    end
    else if (tgl_edge)
    begin
      sy_next.cfg = lk_reg.cfg;
    end
    // free-running internal tone oscillator
    if (sy_reg.osc_cnt == 10'(`TONE_HALF_CYC - 1))
    begin
      sy_next.osc_cnt = 10'h000;
      sy_next.osc     = ~sy_reg.osc;
    end
    else
    begin
      sy_next.osc_cnt = sy_reg.osc_cnt + 10'h001;
    end
    // tone source; both bits set is treated like internal continuous
    unique case ({sy_reg.cfg.ent, sy_reg.cfg.msel})
      2'b00: sy_next.tone_out = sy_reg.osc & sy_reg.ext_s2;
      2'b01: sy_next.tone_out = sy_reg.ext_s2;
      2'b10: sy_next.tone_out = sy_reg.osc & sy_reg.cfg.ent;
      2'b11: sy_next.tone_out = sy_reg.osc;
    endcase
    // threshold is the or of the bit and the transmit pin
    sy_next.thr_tx = sy_reg.cfg.tth | sy_reg.tx_s2;
    // current limit
    if (!sy_reg.cfg.rng)
    begin
      sy_next.ilim = ILIM_275;
    end
    else
    begin
      unique case ({sy_reg.cfg.hi, sy_reg.cfg.lo})
        2'b00: sy_next.ilim = ILIM_350;
        2'b01: sy_next.ilim = ILIM_515;
        2'b10: sy_next.ilim = ILIM_635;
        2'b11: sy_next.ilim = ILIM_800;
      endcase
    end
    sy_next.dyn_en   = ~sy_reg.cfg.dcl;
    sy_next.boost_en = sy_reg.cfg.en;
    sy_next.ldo_en   = sy_reg.cfg.en;
    // voltage selection, pin honoured only while not disabled
    if (sy_reg.cfg.vspen)
    begin
      sy_next.vout = vout_sel_e'({sy_reg.cfg.vtop, sy_reg.cfg.vbot});
    end
    else if (!sy_reg.hr_s2)
    begin
      sy_next.vout = sy_reg.cfg.vbot ? VOUT_14V : VOUT_13V;
    end
    else
    begin
      sy_next.vout = sy_reg.cfg.vtop ? VOUT_19V : VOUT_18V;
    end
    if (rst)
    begin
      sy_next = '0;
    end
    sy_next.pg_s1  = power_good;
    sy_next.pg_s2  = sy_reg.pg_s1;
    sy_next.tgl_s1 = lk_reg.wr_tgl;
    sy_next.tgl_s2 = sy_reg.tgl_s1;
    sy_next.ext_s1 = ext_mod_in_ch2;
    sy_next.ext_s2 = sy_reg.ext_s1;
    sy_next.hr_s1  = high_range_pin_ch2;
    sy_next.hr_s2  = sy_reg.hr_s1;
    sy_next.tx_s1  = tone_tx_pin_ch2;
    sy_next.tx_s2  = sy_reg.tx_s1;
  end

  // system domain register
  always_ff @(posedge clk)
  begin
    sy_reg <= sy_next;
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------
  assign sda_out            = lk_reg.sda_o;
  assign sda_oe             = lk_reg.sda_oe;
  assign tone_out_ch2       = sy_reg.tone_out;
  assign tone_thresh_tx_ch2 = sy_reg.thr_tx;
  assign ilim_sel_ch2       = sy_reg.ilim;
  assign dyn_limit_en_ch2   = sy_reg.dyn_en;
  assign boost_en_ch2       = sy_reg.boost_en;
  assign ldo_en_ch2         = sy_reg.ldo_en;
  assign vout_sel_ch2       = sy_reg.vout;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_lockout2;
    !sy_reg.pg_s2 [*2];
  endsequence

  property p_lockout_off;
    @(posedge clk) disable iff (rst)
    s_lockout2 |=> !boost_en_ch2 && !ldo_en_ch2 && sy_reg.cfg == '0;
  endproperty
  a_lockout_off: assert property (p_lockout_off) else $error("outputs live in lockout");

  property p_disable;
    @(posedge clk) disable iff (rst)
    !sy_reg.cfg.en |=> !boost_en_ch2 && !ldo_en_ch2;
  endproperty
  a_disable: assert property (p_disable) else $error("stage on while disabled");

  property p_ext_pass;
    @(posedge clk) disable iff (rst)
    (!sy_reg.cfg.ent && sy_reg.cfg.msel) |=> tone_out_ch2 == $past(sy_reg.ext_s2);
  endproperty
  a_ext_pass: assert property (p_ext_pass) else $error("ext tone not passed");

  property p_int_gate;
    @(posedge clk) disable iff (rst)
    (!sy_reg.cfg.ent && !sy_reg.cfg.msel && !sy_reg.ext_s2) |=> !tone_out_ch2;
  endproperty
  a_int_gate: assert property (p_int_gate) else $error("tone not gated by pin");

  property p_lim_low;
    @(posedge clk) disable iff (rst)
    !sy_reg.cfg.rng |=> ilim_sel_ch2 == ILIM_275;
  endproperty
  a_lim_low: assert property (p_lim_low) else $error("low range limit wrong");

  property p_vpin_off;
    @(posedge clk) disable iff (rst)
    sy_reg.cfg.vspen |=> vout_sel_ch2 == $past({sy_reg.cfg.vtop, sy_reg.cfg.vbot});
  endproperty
  a_vpin_off: assert property (p_vpin_off) else $error("register voltage wrong");

  property p_vpin_low;
    @(posedge clk) disable iff (rst)
    (!sy_reg.cfg.vspen && !sy_reg.hr_s2) |=> !vout_sel_ch2[1]
      && vout_sel_ch2[0] == $past(sy_reg.cfg.vbot);
  endproperty
  a_vpin_low: assert property (p_vpin_low) else $error("low range voltage wrong");

  property p_vpin_high;
    @(posedge clk) disable iff (rst)
    (!sy_reg.cfg.vspen && sy_reg.hr_s2) |=> vout_sel_ch2[1]
      && vout_sel_ch2[0] == $past(sy_reg.cfg.vtop);
  endproperty
  a_vpin_high: assert property (p_vpin_high) else $error("high range voltage wrong");

  sequence s_addr_miss;
    lk_reg.state == LK_ADDR && lk_reg.cnt == `BYTE_BITS && lk_reg.scl_d
      && !lk_reg.scl_s2 && lk_reg.shift[7:1] != {`ADDR_BASE, lk_reg.strap_s2};
  endsequence

  property p_addr_miss;
    @(posedge link_clk) disable iff (lk_reg.rst_s2)
    s_addr_miss |=> !sda_oe [*2];
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign address acked");

  property p_nack_end;
    @(posedge link_clk) disable iff (lk_reg.rst_s2 || !lk_reg.pg_s2)
    (lk_reg.state == LK_READ_ACK && !lk_reg.mack && lk_reg.scl_d && !lk_reg.scl_s2
      && !(lk_reg.scl_s2 && !lk_reg.sda_s2)) |=> lk_reg.state == LK_IDLE && !sda_oe;
  endproperty
  a_nack_end: assert property (p_nack_end) else $error("read not ended by nack");

endmodule // lnb_ch2_i2c_control_regs

/* File: bus_master_model.sv */
// two-wire bus master model that drives the device's bus pins
module bus_master_model
(
  // pacing clock, every change lands on its falling edge
  input  wire logic clk,
  // wired data line level
  input  wire logic sda,
  // bus clock, idles high like its pull-up
  output logic      scl,
  // high while the master pulls data low
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial scl = 1'b1;
  initial sda_low = 1'b0;

  // wait n falling edges
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask

  // one bit slot: data set while scl low, sampled mid-high
  // four cycles a phase keeps scl well over six link periods
  task automatic bit_slot(input logic v, output logic s);
    sda_low = ~v;
    hold(4);
    scl = 1'b1;
    hold(2);
    s = sda;
    hold(2);
    scl = 1'b0;
  endtask

  // start or repeated start: data falls while scl high
  task automatic start();
    sda_low = 1'b0;
    hold(2);
    scl = 1'b1;
    hold(4);
    sda_low = 1'b1;
    hold(4);
    scl = 1'b0;
  endtask

  // stop: data rises while scl high, then both released
  task automatic stop();
    sda_low = 1'b1;
    hold(2);
    scl = 1'b1;
    hold(4);
    sda_low = 1'b0;
    hold(4);
  endtask

  // send a byte msb first, return the device's acknowledge
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_slot(b[i], s);
    bit_slot(1'b1, s);
    ack = ~s;
  endtask

  // take a byte msb first; ack asks for more, nack ends it
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_slot(1'b1, b[i]);
    bit_slot(last, s);
  endtask
endmodule // bus_master_model

/* File: lnb_ch2_i2c_control_regs_tb_top.sv */
// self-checking bench for the channel-2 supply control register interface
`include "lnb_ch2_consts.svh"
module lnb_ch2_i2c_control_regs_tb_top import lnb_ch2_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, link_clk = 1'b0, rst = 1'b1, power_good = 1'b1;
  logic [1:0] strap = 2'h0;
  logic ext = 1'b0, hr = 1'b0, tx = 1'b0;
  logic [6:0] diag = 7'h00; // otf, cur1, volt1, tone1, cur2, volt2, tone2
  logic scl, sda_low, sda_out, sda_oe, tone, thr, dyn, boost, ldo, a;
  logic [2:0] ilim;
  logic [1:0] vout;
  logic [4:0] tv = 5'h00, cv = 5'h00, kv = 5'h00;
  logic [7:0] b[4];
  int miscompares = 0, cmp_count = 0, n;
  wire logic sda;
  assign sda = ~(sda_low | sda_oe); // open drain with pull-up

  always #12.5 clk = ~clk;
  initial
  begin
    #3.7;
    forever #6 link_clk = ~link_clk; // phase unrelated to clk
  end

  bus_master_model m (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  lnb_ch2_i2c_control_regs dut (.clk(clk), .rst(rst), .link_clk(link_clk),
    .power_good(power_good), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .address_strap_0(strap[0]), .address_strap_1(strap[1]),
    .ext_mod_in_ch2(ext), .high_range_pin_ch2(hr), .tone_tx_pin_ch2(tx),
    .over_temp_flag(diag[6]), .current_fault_ch1(diag[5]), .voltage_fault_ch1(diag[4]),
    .tone_present_ch1(diag[3]), .current_fault_ch2(diag[2]),
    .voltage_fault_ch2(diag[1]), .tone_present_ch2(diag[0]), .tone_out_ch2(tone),
    .tone_thresh_tx_ch2(thr), .ilim_sel_ch2(ilim), .dyn_limit_en_ch2(dyn),
    .boost_en_ch2(boost), .ldo_en_ch2(ldo), .vout_sel_ch2(vout));

  // compare and count
  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // expected voltage code from pin-disable, range pin and select bits
  function automatic logic [7:0] exp_vout(input logic [4:0] c, k, input logic p);
    return 8'(c[3] ? k[1:0] : (p ? {1'b1, k[1]} : {1'b0, k[0]}));
  endfunction

  // address byte; ack expected only for the strap address
  task automatic addr(input logic [1:0] s, input logic rw, input logic e);
    m.start();
    m.wbyte({`ADDR_BASE, s, rw}, a);
    check("ack", 8'(e), 8'(a));
  endtask

  // ignored junk byte, then tone, command, and control last
  task automatic wr_cfg(input logic e);
    addr(strap, 1'b0, e);
    m.wbyte({3'($urandom % 5), 5'($urandom)}, a);
    m.wbyte({`SEL_TONE, tv}, a);
    m.wbyte({`SEL_CMD, cv}, a);
    m.wbyte({`SEL_CTRL, kv}, a);
    m.stop();
    m.hold(40);
  endtask

  // count tone rises over 2000 cycles
  task automatic rises();
    logic p;
    n = 0;
    p = tone;
    repeat (2000)
    begin
      @(negedge clk);
      n += int'(tone & ~p);
      p = tone;
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog: about two and a half times the expected run, well inside the cycle budget
  initial
  begin
    #1500000;
    miscompares++;
    $display("[ERR] watchdog expected end seen hang");
    results();
  end

  initial
  begin
    void'($urandom(32'h0813));
    m.hold(20);
    rst = 1'b0;
    m.hold(10);
    check("reset", 8'h01, {boost, ldo, vout, ilim, dyn});
    check("sda_out", 8'h00, 8'(sda_out));
    $display("test reset done");
    for (int s = 0; s < 8; s++)
    begin
      strap = 2'(s >> 1);
      m.hold(10);
      addr(strap ^ 2'(s & 1), 1'b0, ~s[0]);
      m.stop();
    end
    $display("test address done");
    for (int i = 0; i < 16; i++)
    begin
      tv = 5'($urandom);
      cv = {1'($urandom), 4'(i)};
      kv = 5'($urandom);
      hr = 1'($urandom);
      tx = 1'($urandom);
      ext = 1'($urandom);
      strap = 2'($urandom);
      diag = 7'($urandom);
      wr_cfg(1'b1);
      check("vout", exp_vout(cv, kv, hr), 8'(vout));
      check("ilim", 8'(cv[2] ? 3'h1 + cv[1:0] : 3'h0), 8'(ilim));
      check("dyn", 8'(!cv[4]), 8'(dyn));
      check("pwr", 8'({2{kv[4]}}), 8'({boost, ldo}));
      check("thr", 8'(tv[2] | tx), 8'(thr));
      addr(strap, 1'b1, 1'b1);
      for (int j = 0; j < 4; j++)
        m.rbyte(j == 3, b[j]);
      m.stop();
      check("rd0", {`SEL_TONE, tv[4:2], diag[0], diag[6]}, b[0]);
      check("rd1", {`SEL_CMD, cv}, b[1]);
      check("rd2", {`SEL_CTRL, kv[4], diag[2:1], kv[1:0]}, b[2]);
      check("rd3", {diag, 1'b0}, b[3]);
    end
    $display("test config done");
    tv = 5'h00;
    ext = 1'b0;
    wr_cfg(1'b1);
    rises();
    check("tone_gated", 8'h00, 8'(n));
    ext = 1'b1;
    rises();
    check("tone_pin_on", 8'h01, 8'(n > 0));
    tv = 5'h08;
    wr_cfg(1'b1);
    rises();
    check("tone_ext", 8'h01, {7'h0, tone} + 8'(n));
    ext = 1'b0;
    m.hold(5);
    check("tone_ext_lo", 8'h00, 8'(tone));
    tv = 5'h10;
    ext = 1'b0;
    wr_cfg(1'b1);
    rises();
    check("tone_bit", 8'h01, 8'(n > 0));
    $display("test tone done");
    power_good = 1'b0;
    m.hold(10);
    check("pg_low", 8'h00, 8'({boost, ldo}));
    wr_cfg(1'b0);
    power_good = 1'b1;
    m.hold(20);
    check("pg_back", exp_vout(5'h00, 5'h00, hr), 8'({boost, ldo, vout}));
    $display("test power good done");
    results();
  end
endmodule // lnb_ch2_i2c_control_regs_tb_top
